/* File: rtl/sbcsf_params.svh */
// Purpose: Offsets, field positions, codes and reset values of the status flag registers.
// Assumes: Twelve-bit registers addressed by a three-bit register address.
// Notes:   Definitions only.
`ifndef SBCSF_PARAMS_SVH
`define SBCSF_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SBCSF_ADDR_FSW      3'h5
`define SBCSF_ADDR_MIRROR   3'h6
// ----------------------------------------
// Field positions in failsafe_wake_flags
// ----------------------------------------
`define SBCSF_CAUSE_LSB     0
`define SBCSF_WAKE_LOCAL    4
`define SBCSF_WAKE_CAN      5
`define SBCSF_WAKE_LIN1     6
`define SBCSF_WAKE_LIN2     7
`define SBCSF_WAKE_TIMER    8
// ----------------------------------------
// Fail-safe cause codes and reset values
// ----------------------------------------
`define SBCSF_CAUSE_NONE    4'h0
`define SBCSF_CAUSE_EXT_RST 4'h3
`define SBCSF_REG_ZERO      12'h000
`endif

/* File: rtl/sbcsf_pkg.sv */
// Purpose: Types shared by the status flag register block.
// Assumes: Mode codes come from the mode controller on the same clock.
// Notes:   Holds types only; numbers live in the params header.
package sbcsf_pkg;
  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    SBCSF_CONFIG, SBCSF_RESET, SBCSF_STARTUP, SBCSF_NORMAL,
    SBCSF_STANDBY, SBCSF_SLEEP, SBCSF_FAILSAFE, SBCSF_SHUTDOWN
  } sbcsf_mode_t;
  // Register access request from the serial frame decoder.
  typedef struct packed {
    logic       rd;
    logic       rc;
    logic       wr;
    logic [2:0] addr;
  } sbcsf_acc_t;
  // Converter, supply and comparator levels.
  typedef struct packed {
    logic vs_low;
    logic stepdown_unregulated;
    logic stepdown_overload;
    logic stepup_running;
    logic stepup_overload;
    logic thermal_warning;
    logic aux_under;
    logic aux_over;
    logic aux_on;
  } sbcsf_levels_t;
  // Whole state of the block.
  typedef struct packed {
    logic [1:0]  devel_sync;
    logic [1:0]  cfg_sync;
    logic [1:0]  wake_sync;
    logic        wake_prev;
    logic [11:0] flags;
    logic        devel_latched;
    logic        cfg_latched;
    logic [11:0] rdata;
    logic        irq;
    logic        wake_rst;
    logic        evt_clr;
    logic        fso;
  } sbcsf_state_t;
endpackage

/* File: rtl/sbcsf_status_flag_regs.sv */
// Purpose: Fail-safe/wakeup flag register and internal-state mirror register.
// Assumes: Events and levels come from same-clock logic; the three pins are synchronised here.
// Notes:   Power-on reset clears everything but sets the event flag clear; the Reset mode of the device keeps the flags.
//
// Contract
// - Fail-safe and wake events set flags, latched
// - Flags clear only on read-and-clear access, in Configuration mode or at power-on reset
// - Configuration mode loads flag register zeros
// - Reset and Start-up modes keep flags
// - Zero cause means outputs idle unless forced
// - Codes 0010, 0011; 0011 not in devel
// - Fail-safe entry codes 1000 to 1011
// - Thermal 1100, output undervoltage 1101
// - Local pin wake only with mode non-zero
// - Bus wake only in transceiver wake mode
// - Timer wake only when timer wake selected
// - Normal/Standby wake holds interrupt until clear
// - Sleep wake gives reset pulse instead
// - Mirror register ignores clear and write
// - Mirror shows five converter and supply bits
// - Devel pin latched; config pin latched or live
// - Mirror shows wake pin, thermal, aux comparators
// - Internal toggling disturbs no other register
// - Event flag register cleared every reset
`timescale 1ns/100ps
`include "sbcsf_params.svh"
module sbcsf_status_flag_regs (
  input  wire logic                     sys_clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     ce_i,
  input  wire sbcsf_pkg::sbcsf_mode_t   mode_i,
  input  wire sbcsf_pkg::sbcsf_acc_t    acc_i,
  input  wire logic                     cause_evt_i,
  input  wire logic [3:0]               cause_code_i,
  input  wire logic                     failsafe_force_on_i,
  input  wire logic [1:0]               local_pin_wake_mode_i,
  input  wire logic                     local_wake_pin_i,
  input  wire logic                     sw_devel_mode_pin_i,
  input  wire logic                     config_pin_i,
  input  wire logic                     can_wake_evt_i,
  input  wire logic                     can_wake_mode_i,
  input  wire logic                     lin1_wake_evt_i,
  input  wire logic                     lin1_wake_mode_i,
  input  wire logic                     lin2_wake_evt_i,
  input  wire logic                     lin2_wake_mode_i,
  input  wire logic                     timer_wake_evt_i,
  input  wire logic                     timer_wake_sel_i,
  input  wire sbcsf_pkg::sbcsf_levels_t levels_i,
  output logic [11:0]                   rdata_o,
  output logic                          wake_irq_o,
  output logic                          wake_reset_pulse_o,
  output logic                          failsafe_outputs_o,
  output logic                          event_flags_clear_o
);

  sbcsf_pkg::sbcsf_state_t st;
  sbcsf_pkg::sbcsf_state_t next_st;

  // Reserved cause codes: 0100 to 0111, 1110 and 1111.
  function automatic logic cause_reserved(input logic [3:0] c);
    cause_reserved = (c[3:2] == 2'b01) || (c[3:1] == 3'b111);
  endfunction

  // Assembles the mirror register from live and latched levels.
  function automatic logic [11:0] mirror(input sbcsf_pkg::sbcsf_levels_t l, input sbcsf_pkg::sbcsf_state_t s);
    mirror = {1'b0, l.aux_over, l.aux_under & l.aux_on, l.thermal_warning, s.wake_sync[1],
              s.devel_latched ? s.cfg_sync[1] : s.cfg_latched, s.devel_latched,
              l.stepup_overload, l.stepup_running, l.stepdown_overload,
              l.stepdown_unregulated, l.vs_low};
  endfunction

  logic        wake_edge;
  logic [11:0] set_mask;
  logic        cause_ok;
  logic        rc_fsw;
  logic        any_wake;

  // ----------------------------------------
  // Event qualification
  // ----------------------------------------
  always_comb begin
    wake_edge = st.wake_sync[1] ^ st.wake_prev;
    cause_ok  = cause_evt_i && !cause_reserved(cause_code_i)
                && !(st.devel_latched && cause_code_i == `SBCSF_CAUSE_EXT_RST);
    set_mask  = `SBCSF_REG_ZERO;
    set_mask[`SBCSF_WAKE_LOCAL] = wake_edge && (local_pin_wake_mode_i != 2'h0);
    set_mask[`SBCSF_WAKE_CAN]   = can_wake_evt_i && can_wake_mode_i;
    set_mask[`SBCSF_WAKE_LIN1]  = lin1_wake_evt_i && lin1_wake_mode_i;
    set_mask[`SBCSF_WAKE_LIN2]  = lin2_wake_evt_i && lin2_wake_mode_i;
    set_mask[`SBCSF_WAKE_TIMER] = timer_wake_evt_i && timer_wake_sel_i;
    any_wake  = |set_mask;
    rc_fsw    = acc_i.rc && (acc_i.addr == `SBCSF_ADDR_FSW);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.devel_sync = {st.devel_sync[0], sw_devel_mode_pin_i};
    next_st.cfg_sync   = {st.cfg_sync[0], config_pin_i};
    next_st.wake_sync  = {st.wake_sync[0], local_wake_pin_i};
    next_st.wake_prev  = st.wake_sync[1];
    next_st.wake_rst   = 1'b0;
    case (mode_i)
      sbcsf_pkg::SBCSF_CONFIG: begin
        // Initialise flags and catch the pin straps.
        next_st.flags         = `SBCSF_REG_ZERO;
        next_st.devel_latched = st.devel_sync[1];
        next_st.cfg_latched   = st.cfg_sync[1];
        next_st.irq           = 1'b0;
      end
      default: begin
        // Set wins over a simultaneous read-and-clear; Reset and Start-up keep flags.
        if (rc_fsw) begin
          next_st.flags = `SBCSF_REG_ZERO;
          next_st.irq   = 1'b0;
        end
        next_st.flags = next_st.flags | set_mask;
        if (cause_ok) begin
          next_st.flags[`SBCSF_CAUSE_LSB +: 4] = cause_code_i;
        end
        if (any_wake && (mode_i == sbcsf_pkg::SBCSF_NORMAL || mode_i == sbcsf_pkg::SBCSF_STANDBY)) begin
          next_st.irq = 1'b1;
        end
        next_st.wake_rst = any_wake && (mode_i == sbcsf_pkg::SBCSF_SLEEP);
      end
    endcase
    // Fail-safe outputs follow the stored cause or the force-on bit.
    next_st.fso = (next_st.flags[`SBCSF_CAUSE_LSB +: 4] != `SBCSF_CAUSE_NONE) || failsafe_force_on_i;
    next_st.evt_clr = (mode_i == sbcsf_pkg::SBCSF_RESET);
    // Reads return the addressed register; writes change neither register.
    if (acc_i.rd || acc_i.rc) begin
      case (acc_i.addr)
        `SBCSF_ADDR_FSW:    next_st.rdata = st.flags;
        `SBCSF_ADDR_MIRROR: next_st.rdata = mirror(levels_i, st);
        default:            next_st.rdata = `SBCSF_REG_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st <= '0;
      st.evt_clr <= 1'b1;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign rdata_o             = st.rdata;
  assign wake_irq_o          = st.irq;
  assign wake_reset_pulse_o  = st.wake_rst;
  assign failsafe_outputs_o  = st.fso;
  assign event_flags_clear_o = st.evt_clr;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  property p_can_set;
    ce_i && can_wake_evt_i && can_wake_mode_i && mode_i != sbcsf_pkg::SBCSF_CONFIG
      |=> st.flags[`SBCSF_WAKE_CAN];
  endproperty
  a_can_set: assert property (p_can_set) else $error("CAN wake flag not set.");

  property p_flag_fall;
    $fell(st.flags[`SBCSF_WAKE_TIMER])
      |-> $past(rc_fsw) || $past(mode_i) == sbcsf_pkg::SBCSF_CONFIG || $past(srst_i);
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("Flag cleared without clear access.");

  property p_config_zero;
    ce_i && mode_i == sbcsf_pkg::SBCSF_CONFIG |=> st.flags == `SBCSF_REG_ZERO;
  endproperty
  a_config_zero: assert property (p_config_zero) else $error("Flags not zeroed in config.");

  property p_keep_in_reset;
    ce_i && (mode_i == sbcsf_pkg::SBCSF_RESET || mode_i == sbcsf_pkg::SBCSF_STARTUP) && !rc_fsw
      |=> (st.flags[8:4] & $past(st.flags[8:4])) == $past(st.flags[8:4])
          && ($past(cause_evt_i) || st.flags[3:0] == $past(st.flags[3:0]));
  endproperty
  a_keep_in_reset: assert property (p_keep_in_reset) else $error("Flags lost in reset mode.");

  property p_fso;
    $past(ce_i) && !$past(srst_i)
      |-> st.fso == ((st.flags[3:0] != `SBCSF_CAUSE_NONE) || $past(failsafe_force_on_i));
  endproperty
  a_fso: assert property (p_fso) else $error("Fail-safe output mismatch.");

  property p_no_reserved;
    !cause_reserved(st.flags[3:0]);
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("Reserved cause stored.");

  property p_local_mode;
    $rose(st.flags[`SBCSF_WAKE_LOCAL]) |-> $past(local_pin_wake_mode_i) != 2'h0;
  endproperty
  a_local_mode: assert property (p_local_mode) else $error("Local wake flag set with mode zero.");

  property p_irq_hold;
    st.irq && !(ce_i && (rc_fsw || mode_i == sbcsf_pkg::SBCSF_CONFIG)) |=> st.irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("Wake interrupt dropped early.");

  property p_sleep_pulse;
    ce_i && any_wake && mode_i == sbcsf_pkg::SBCSF_SLEEP |=> wake_reset_pulse_o && $stable(st.irq);
  endproperty
  a_sleep_pulse: assert property (p_sleep_pulse) else $error("Sleep wake gave no reset pulse.");

  property p_mirror_write;
    ce_i && acc_i.wr && !acc_i.rd && !acc_i.rc |=> $stable(st.rdata);
  endproperty
  a_mirror_write: assert property (p_mirror_write) else $error("Write changed read data.");

  property p_evt_clr;
    ce_i && mode_i == sbcsf_pkg::SBCSF_RESET |=> event_flags_clear_o;
  endproperty
  a_evt_clr: assert property (p_evt_clr) else $error("Event flags not cleared at reset.");

  // Each remaining wake source lands in its own flag one cycle after it is qualified.
  property p_lin1_set;
    ce_i && lin1_wake_evt_i && lin1_wake_mode_i && mode_i != sbcsf_pkg::SBCSF_CONFIG
      |=> st.flags[`SBCSF_WAKE_LIN1];
  endproperty
  a_lin1_set: assert property (p_lin1_set) else $error("LIN1 wake flag not set.");

  property p_lin2_set;
    ce_i && lin2_wake_evt_i && lin2_wake_mode_i && mode_i != sbcsf_pkg::SBCSF_CONFIG
      |=> st.flags[`SBCSF_WAKE_LIN2];
  endproperty
  a_lin2_set: assert property (p_lin2_set) else $error("LIN2 wake flag not set.");

  property p_timer_set;
    ce_i && timer_wake_evt_i && timer_wake_sel_i && mode_i != sbcsf_pkg::SBCSF_CONFIG
      |=> st.flags[`SBCSF_WAKE_TIMER];
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("Timer wake flag not set.");

  property p_local_set;
    ce_i && wake_edge && local_pin_wake_mode_i != 2'h0 && mode_i != sbcsf_pkg::SBCSF_CONFIG
      |=> st.flags[`SBCSF_WAKE_LOCAL];
  endproperty
  a_local_set: assert property (p_local_set) else $error("Local wake flag not set.");

  // The cause field takes accepted codes and ignores the one that is refused in devel.
  property p_cause_store;
    ce_i && cause_ok && mode_i != sbcsf_pkg::SBCSF_CONFIG |=> st.flags[3:0] == $past(cause_code_i);
  endproperty
  a_cause_store: assert property (p_cause_store) else $error("Cause code not stored.");

  property p_devel_drop;
    ce_i && cause_evt_i && st.devel_latched && cause_code_i == `SBCSF_CAUSE_EXT_RST && !rc_fsw
      && mode_i != sbcsf_pkg::SBCSF_CONFIG |=> st.flags[3:0] == $past(st.flags[3:0]);
  endproperty
  a_devel_drop: assert property (p_devel_drop) else $error("External reset cause stored in devel.");

  // Outside Configuration mode only a read-and-clear of the flag register empties it; without an event nothing else moves it.
  property p_rc_clear;
    ce_i && rc_fsw && !any_wake && !cause_evt_i && mode_i != sbcsf_pkg::SBCSF_CONFIG
      |=> st.flags == `SBCSF_REG_ZERO;
  endproperty
  a_rc_clear: assert property (p_rc_clear) else $error("Read-and-clear left flags set.");

  property p_flags_hold;
    ce_i && !rc_fsw && !any_wake && !cause_evt_i && mode_i != sbcsf_pkg::SBCSF_CONFIG
      |=> st.flags == $past(st.flags);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("Flags changed without an event.");

  // Wakes in Normal or Standby raise the request; a clear with no new wake drops it.
  property p_irq_set;
    ce_i && any_wake && (mode_i == sbcsf_pkg::SBCSF_NORMAL || mode_i == sbcsf_pkg::SBCSF_STANDBY)
      |=> wake_irq_o;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("Wake gave no interrupt request.");

  property p_irq_clear;
    ce_i && rc_fsw && !any_wake |=> !wake_irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("Interrupt request survived clear.");

  property p_pulse_once;
    ce_i && wake_reset_pulse_o && !(any_wake && mode_i == sbcsf_pkg::SBCSF_SLEEP) |=> !wake_reset_pulse_o;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("Reset pulse longer than one cycle.");

  // The mirror shows the live thermal comparator and a zero top bit.
  property p_thermal_live;
    ce_i && acc_i.rd && acc_i.addr == `SBCSF_ADDR_MIRROR
      |=> rdata_o[8] == $past(levels_i.thermal_warning) && rdata_o[11] == 1'b0;
  endproperty
  a_thermal_live: assert property (p_thermal_live) else $error("Mirror thermal bit wrong.");

  // A low clock enable freezes every state bit.
  property p_freeze;
    !ce_i |=> $stable(st);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved with clock enable low.");

  property p_evt_clr_end;
    ce_i && mode_i != sbcsf_pkg::SBCSF_RESET |=> !event_flags_clear_o;
  endproperty
  a_evt_clr_end: assert property (p_evt_clr_end) else $error("Event flag clear held too long.");

  c_irq:    cover property (ce_i && any_wake && mode_i == sbcsf_pkg::SBCSF_NORMAL ##1 wake_irq_o);
  c_sleep:  cover property (wake_reset_pulse_o);
  c_rc_set: cover property (ce_i && rc_fsw && any_wake);
  c_cause:  cover property (ce_i && cause_ok ##1 failsafe_outputs_o);
  c_freeze: cover property (!ce_i && lin2_wake_evt_i);

endmodule

/* File: verification/sbcsf_host_model.sv */
// Purpose: Host model that issues register accesses to the flag block.
// Assumes: One access per call; the answer is taken one cycle later.
// Notes:   Never consults the event flag register.
`timescale 1ns/100ps
module sbcsf_host_model (
  input  wire logic             sys_clk_i,
  input  wire logic [11:0]      rdata_i,
  output sbcsf_pkg::sbcsf_acc_t acc_o
);
  // ----------------------------------------
  // Access sequencing
  // ----------------------------------------
  // Idle bus until the first access.
  initial acc_o = '0;
  // Holds one strobe for a single edge, then takes the read data.
  task automatic access(input logic [2:0] kind, input logic [2:0] addr, output logic [11:0] data);
    @(posedge sys_clk_i);
    #1 acc_o = {kind, addr};
    @(posedge sys_clk_i);
    #1 acc_o = '0;
    data = rdata_i;
  endtask
endmodule

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the status flag registers.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Expected values come from the register layout alone.
`timescale 1ns/100ps
`include "sbcsf_params.svh"
module testbench;
  localparam logic [2:0] RD = 3'h4, RC = 3'h2, WR = 3'h1;
  logic sys_clk_i = 1'b0, srst_i = 1'b1, evt = 1'b0, force_on = 1'b0;
  logic lw_pin = 1'b0, devel = 1'b0, cfg = 1'b0, ce = 1'b1, irq, rpulse, fs_out, evclr;
  logic [1:0] lw_mode = 2'h0;
  logic [3:0] code = 4'h0, wk_evt = 4'h0, wk_q = 4'h0;
  logic [11:0] rdata, d;
  sbcsf_pkg::sbcsf_mode_t mode = sbcsf_pkg::SBCSF_CONFIG;
  sbcsf_pkg::sbcsf_acc_t acc;
  sbcsf_pkg::sbcsf_levels_t lv = '0;
  int errors = 0, n_compared = 0, cycles = 0, n_pulse = 0, k;
  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  sbcsf_status_flag_regs i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce), .mode_i(mode),
    .acc_i(acc), .cause_evt_i(evt), .cause_code_i(code), .failsafe_force_on_i(force_on),
    .local_pin_wake_mode_i(lw_mode), .local_wake_pin_i(lw_pin), .sw_devel_mode_pin_i(devel),
    .config_pin_i(cfg), .can_wake_evt_i(wk_evt[0]), .can_wake_mode_i(wk_q[0]),
    .lin1_wake_evt_i(wk_evt[1]), .lin1_wake_mode_i(wk_q[1]), .lin2_wake_evt_i(wk_evt[2]),
    .lin2_wake_mode_i(wk_q[2]), .timer_wake_evt_i(wk_evt[3]), .timer_wake_sel_i(wk_q[3]),
    .levels_i(lv), .rdata_o(rdata), .wake_irq_o(irq), .wake_reset_pulse_o(rpulse),
    .failsafe_outputs_o(fs_out), .event_flags_clear_o(evclr));
  sbcsf_host_model i_host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .acc_o(acc));
  // Clock, pulse counter and hang limit.
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test();
    end
  end
  // Pulses are counted at the falling edge, where the registered output has settled.
  always @(negedge sys_clk_i) begin
    if (rpulse === 1'b1) n_pulse++;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cause(input logic [3:0] c);
    step(1);
    code = c;
    evt = 1'b1;
    step(1);
    evt = 1'b0;
  endtask
  task automatic wake(input int i, input logic q);
    wk_q[i] = q;
    step(1);
    wk_evt[i] = 1'b1;
    step(1);
    wk_evt[i] = 1'b0;
    step(1);
  endtask
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_config;
    chk("clear", 12'h1, {11'h0, evclr});
    step(1);
    srst_i = 1'b0;
    i_host.access(RD, `SBCSF_ADDR_FSW, d);
    chk("flags", `SBCSF_REG_ZERO, d);
    chk("fs_out", 12'h0, {11'h0, fs_out});
    force_on = 1'b1;
    step(2);
    chk("fs_out", 12'h1, {11'h0, fs_out});
    force_on = 1'b0;
    mode = sbcsf_pkg::SBCSF_NORMAL;
  endtask
  task automatic t_causes;
    for (k = 0; k < 16; k++) begin
      cause(k[3:0]);
      chk("fs_out", {11'h0, (k != 0) && !(k[3:2] == 2'h1 || k[3:1] == 3'h7)}, {11'h0, fs_out});
      i_host.access(RC, `SBCSF_ADDR_FSW, d);
      chk("cause", (k[3:2] == 2'h1 || k[3:1] == 3'h7) ? 12'h0 : {8'h0, k[3:0]}, d);
    end
  endtask
  task automatic t_wakes;
    for (k = 0; k < 4; k++) begin
      wake(k, 1'b0);
      i_host.access(RD, `SBCSF_ADDR_FSW, d);
      chk("unqualified", 12'h0, d);
      wake(k, 1'b1);
      i_host.access(RD, `SBCSF_ADDR_FSW, d);
      i_host.access(RD, `SBCSF_ADDR_FSW, d);
      chk("wake", 12'h1 << (`SBCSF_WAKE_CAN + k), d);
      chk("irq", 12'h1, {11'h0, irq});
      i_host.access(RC, `SBCSF_ADDR_FSW, d);
      step(1);
      chk("irq", 12'h0, {11'h0, irq});
      i_host.access(RD, `SBCSF_ADDR_FSW, d);
      chk("cleared", 12'h0, d);
      wk_q[k] = 1'b0;
    end
    for (k = 0; k < 2; k++) begin
      lw_mode = k[1:0];
      lw_pin = ~lw_pin;
      step(5);
      i_host.access(RC, `SBCSF_ADDR_FSW, d);
      chk("local", k ? 12'h1 << `SBCSF_WAKE_LOCAL : 12'h0, d);
    end
  endtask
  task automatic t_modes;
    wake(0, 1'b1);
    mode = sbcsf_pkg::SBCSF_RESET;
    step(2);
    chk("clear", 12'h1, {11'h0, evclr});
    mode = sbcsf_pkg::SBCSF_STARTUP;
    step(2);
    i_host.access(RC, `SBCSF_ADDR_FSW, d);
    chk("kept", 12'h1 << `SBCSF_WAKE_CAN, d);
    mode = sbcsf_pkg::SBCSF_SLEEP;
    k = n_pulse;
    wake(1, 1'b1);
    step(2);
    chk("pulses", 12'h1, 12'(n_pulse - k));
    chk("irq", 12'h0, {11'h0, irq});
    mode = sbcsf_pkg::SBCSF_CONFIG;
    devel = 1'b1;
    cfg = 1'b1;
    step(4);
    mode = sbcsf_pkg::SBCSF_NORMAL;
    i_host.access(RD, `SBCSF_ADDR_FSW, d);
    chk("zeroed", `SBCSF_REG_ZERO, d);
  endtask
  task automatic t_mirror;
    cfg = 1'b0;
    step(4);
    i_host.access(RD, `SBCSF_ADDR_MIRROR, d);
    chk("straps", 12'h1, {10'h0, d[6:5]});
    cause(`SBCSF_CAUSE_EXT_RST);
    i_host.access(RC, `SBCSF_ADDR_FSW, d);
    chk("devel cause", 12'h0, d);
    for (k = 0; k < 2; k++) begin
      lv = k ? 9'h0aa : 9'h1ff;
      step(3);
      i_host.access(WR, `SBCSF_ADDR_MIRROR, d);
      i_host.access(RC, `SBCSF_ADDR_MIRROR, d);
      i_host.access(RD, `SBCSF_ADDR_MIRROR, d);
      chk("mirror", {1'b0, lv.aux_over, lv.aux_under & lv.aux_on, lv.thermal_warning, lw_pin, 2'h1,
        lv.stepup_overload, lv.stepup_running, lv.stepdown_overload, lv.stepdown_unregulated,
        lv.vs_low}, d);
    end
    i_host.access(RD, 3'h7, d);
    chk("unmapped", 12'h0, d);
    mode = sbcsf_pkg::SBCSF_CONFIG;
    devel = 1'b0;
    cfg = 1'b1;
    step(4);
    mode = sbcsf_pkg::SBCSF_NORMAL;
    cfg = 1'b0;
    step(4);
    i_host.access(RD, `SBCSF_ADDR_MIRROR, d);
    chk("latched cfg", 12'h2, {10'h0, d[6:5]});
  endtask
  // Clock enable low swallows a wake; in Standby a wake then raises the request.
  task automatic t_freeze;
    mode = sbcsf_pkg::SBCSF_STANDBY;
    ce = 1'b0;
    wake(2, 1'b1);
    chk("frozen irq", 12'h0, {11'h0, irq});
    ce = 1'b1;
    i_host.access(RD, `SBCSF_ADDR_FSW, d);
    chk("frozen", `SBCSF_REG_ZERO, d);
    wake(2, 1'b1);
    chk("standby irq", 12'h1, {11'h0, irq});
    i_host.access(RC, `SBCSF_ADDR_FSW, d);
    chk("standby wake", 12'h1 << `SBCSF_WAKE_LIN2, d);
    wk_q[2] = 1'b0;
    mode = sbcsf_pkg::SBCSF_NORMAL;
  endtask
  // Main sequence: 16 cycles of reset, then every scenario.
  initial begin
    repeat (15) @(posedge sys_clk_i);
    #1;
    t_config();
    t_causes();
    t_wakes();
    t_modes();
    t_freeze();
    t_mirror();
    finish_test();
  end
endmodule
